/* design/acfg_top.sv */
// Configuration registers and test-pattern insertion for a dual-channel converter.
// Assumes register writes, reads and sample data all arrive on CLK; the bit
// mapper, output format stage and interface select register sit outside.
module acfg_top (
	input  wire logic                               CLK,
	input  wire logic                               RSTN,
	input  wire logic                               REG_WE,
	input  wire logic [7:0]                         REG_ADDR,
	input  wire logic [7:0]                         REG_WDATA,
	output logic      [7:0]                         REG_RDATA,
	input  wire logic [acfg_pkg::IF_SEL_BITS-1:0]   IF_SEL,
	input  wire logic [acfg_pkg::NATIVE_BITS-1:0]   ADC_A_DATA,
	input  wire logic [acfg_pkg::NATIVE_BITS-1:0]   ADC_B_DATA,
	input  wire logic                               ADC_VALID,
	output logic      [acfg_pkg::NATIVE_BITS-1:0]   MAP_A_DATA,
	output logic      [acfg_pkg::NATIVE_BITS-1:0]   MAP_B_DATA,
	output logic                                    MAP_VALID,
	output logic                                    CHAN_A_SINGLE_ENDED,
	output logic                                    CHAN_B_SINGLE_ENDED,
	output logic                                    DELAY_LOOP_POWERDOWN,
	output logic                                    SAMPLE_TIME_QUARTER,
	output logic                                    AUTOZERO_ENABLE,
	output logic                                    MAPPING_LOAD,
	output logic      [acfg_pkg::IF_SEL_BITS-1:0]   MAPPING_SEL
);

	// =================================================================
	// Register file
	logic [7:0] input_ctl_ff;
	logic [7:0] nxt_input_ctl;
	logic [7:0] load_strobe_ff;
	logic [7:0] nxt_load_strobe;
	logic [7:0] pat_low_ff;
	logic [7:0] nxt_pat_low;
	logic [7:0] pat_mid_ff;
	logic [7:0] nxt_pat_mid;
	logic [7:0] pat_high_ff;
	logic [7:0] nxt_pat_high;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic       load_done;

	// A load completes when the load bit is written from one back to zero.
	assign load_done = REG_WE && (REG_ADDR == acfg_pkg::OFS_MAPPING_LOAD_STROBE)
		&& load_strobe_ff[acfg_pkg::POS_MAPPING_LOAD_BIT]
		&& !REG_WDATA[acfg_pkg::POS_MAPPING_LOAD_BIT];

	always_comb begin
		nxt_input_ctl   = input_ctl_ff;
		nxt_load_strobe = load_strobe_ff;
		nxt_pat_low     = pat_low_ff;
		nxt_pat_mid     = pat_mid_ff;
		nxt_pat_high    = pat_high_ff;
		if (load_done) begin
			// The mapping load wipes earlier configuration writes.
			nxt_input_ctl   = acfg_pkg::RST_INPUT_SAMPLING_CONTROL;
			nxt_pat_low     = acfg_pkg::RST_PATTERN_VALUE_LOW;
			nxt_pat_mid     = acfg_pkg::RST_PATTERN_VALUE_MID;
			nxt_pat_high    = acfg_pkg::RST_PATTERN_SELECT_HIGH;
			nxt_load_strobe = acfg_pkg::RST_MAPPING_LOAD_STROBE;
		end else if (REG_WE) begin
			case (REG_ADDR)
				acfg_pkg::OFS_INPUT_SAMPLING_CONTROL: begin
					nxt_input_ctl = REG_WDATA & acfg_pkg::MASK_INPUT_SAMPLING_CONTROL;
				end
				acfg_pkg::OFS_MAPPING_LOAD_STROBE: begin
					nxt_load_strobe = REG_WDATA & acfg_pkg::MASK_MAPPING_LOAD_STROBE;
				end
				acfg_pkg::OFS_PATTERN_VALUE_LOW: begin
					nxt_pat_low = REG_WDATA;
				end
				acfg_pkg::OFS_PATTERN_VALUE_MID: begin
					nxt_pat_mid = REG_WDATA;
				end
				acfg_pkg::OFS_PATTERN_SELECT_HIGH: begin
					nxt_pat_high = REG_WDATA;
				end
				default: begin
					nxt_input_ctl = input_ctl_ff;
				end
			endcase
		end
	end

	always_comb begin
		case (REG_ADDR)
			acfg_pkg::OFS_INPUT_SAMPLING_CONTROL: nxt_rdata = input_ctl_ff;
			acfg_pkg::OFS_MAPPING_LOAD_STROBE:    nxt_rdata = load_strobe_ff;
			acfg_pkg::OFS_PATTERN_VALUE_LOW:      nxt_rdata = pat_low_ff;
			acfg_pkg::OFS_PATTERN_VALUE_MID:      nxt_rdata = pat_mid_ff;
			acfg_pkg::OFS_PATTERN_SELECT_HIGH:    nxt_rdata = pat_high_ff;
			default:                              nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			input_ctl_ff   <= acfg_pkg::RST_INPUT_SAMPLING_CONTROL;
			load_strobe_ff <= acfg_pkg::RST_MAPPING_LOAD_STROBE;
			pat_low_ff     <= acfg_pkg::RST_PATTERN_VALUE_LOW;
			pat_mid_ff     <= acfg_pkg::RST_PATTERN_VALUE_MID;
			pat_high_ff    <= acfg_pkg::RST_PATTERN_SELECT_HIGH;
			rdata_ff       <= 8'h00;
		end else begin
			input_ctl_ff   <= nxt_input_ctl;
			load_strobe_ff <= nxt_load_strobe;
			pat_low_ff     <= nxt_pat_low;
			pat_mid_ff     <= nxt_pat_mid;
			pat_high_ff    <= nxt_pat_high;
			rdata_ff       <= nxt_rdata;
		end
	end

	assign REG_RDATA = rdata_ff;

	// =================================================================
	// Analog control outputs and mapping load
	logic                               se_a_ff;
	logic                               nxt_se_a;
	logic                               se_b_ff;
	logic                               nxt_se_b;
	logic                               delay_loop_powerdown_ff;
	logic                               nxt_delay_loop_powerdown;
	logic                               quarter_ff;
	logic                               nxt_quarter;
	logic                               az_ff;
	logic                               nxt_az;
	logic                               map_load_ff;
	logic                               nxt_map_load;
	logic [acfg_pkg::IF_SEL_BITS-1:0]   map_sel_ff;
	logic [acfg_pkg::IF_SEL_BITS-1:0]   nxt_map_sel;

	always_comb begin
		nxt_se_a     = input_ctl_ff[acfg_pkg::POS_CHAN_A_SINGLE_ENDED];
		nxt_se_b     = input_ctl_ff[acfg_pkg::POS_CHAN_B_SINGLE_ENDED];
		nxt_delay_loop_powerdown  = input_ctl_ff[acfg_pkg::POS_DELAY_LOOP_POWERDOWN];
		nxt_quarter  = !input_ctl_ff[acfg_pkg::POS_DELAY_LOOP_POWERDOWN];
		nxt_az       = input_ctl_ff[acfg_pkg::POS_AUTOZERO_ENABLE];
		nxt_map_load = load_done;
		nxt_map_sel  = load_done ? IF_SEL : map_sel_ff;
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			se_a_ff     <= 1'b0;
			se_b_ff     <= 1'b0;
			delay_loop_powerdown_ff  <= 1'b0;
			quarter_ff  <= 1'b1;
			az_ff       <= 1'b0;
			map_load_ff <= 1'b0;
			map_sel_ff  <= '0;
		end else begin
			se_a_ff     <= nxt_se_a;
			se_b_ff     <= nxt_se_b;
			delay_loop_powerdown_ff  <= nxt_delay_loop_powerdown;
			quarter_ff  <= nxt_quarter;
			az_ff       <= nxt_az;
			map_load_ff <= nxt_map_load;
			map_sel_ff  <= nxt_map_sel;
		end
	end

	assign CHAN_A_SINGLE_ENDED  = se_a_ff;
	assign CHAN_B_SINGLE_ENDED  = se_b_ff;
	assign DELAY_LOOP_POWERDOWN = delay_loop_powerdown_ff;
	assign SAMPLE_TIME_QUARTER  = quarter_ff;
	assign AUTOZERO_ENABLE      = az_ff;
	assign MAPPING_LOAD         = map_load_ff;
	assign MAPPING_SEL          = map_sel_ff;

	// =================================================================
	// Test-pattern insertion ahead of the bit mapper
	logic [acfg_pkg::PATTERN_BITS-1:0] pattern_value;
	logic [acfg_pkg::NATIVE_BITS-1:0]  ch_in   [acfg_pkg::CHANNELS];
	logic [acfg_pkg::NATIVE_BITS-1:0]  ch_out  [acfg_pkg::CHANNELS];
	logic [acfg_pkg::SEL_BITS-1:0]     ch_sel  [acfg_pkg::CHANNELS];
	logic                              valid_ff;
	logic                              nxt_valid;

	assign pattern_value = {pat_high_ff[acfg_pkg::POS_PATTERN_HIGH_LSB +: 2],
		pat_mid_ff, pat_low_ff};
	assign ch_in[0]  = ADC_A_DATA;
	assign ch_in[1]  = ADC_B_DATA;
	assign ch_sel[0] = pat_high_ff[acfg_pkg::POS_CHAN_A_SEL_LSB +: acfg_pkg::SEL_BITS];
	assign ch_sel[1] = pat_high_ff[acfg_pkg::POS_CHAN_B_SEL_LSB +: acfg_pkg::SEL_BITS];

	// Patterns replace raw words before any format or mapping stage, so
	// both output formats and every mapping see them like real samples.
	for (genvar ch = 0; ch < acfg_pkg::CHANNELS; ch++) begin : g_chan
		acfg_pgen u_pgen (
			.CLK      (CLK),
			.RSTN     (RSTN),
			.SEL      (ch_sel[ch]),
			.VALUE    (pattern_value),
			.DATA_IN  (ch_in[ch]),
			.VALID_IN (ADC_VALID),
			.DATA_OUT (ch_out[ch])
		);
	end

	always_comb begin
		nxt_valid = ADC_VALID;
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			valid_ff <= 1'b0;
		end else begin
			valid_ff <= nxt_valid;
		end
	end

	assign MAP_A_DATA = ch_out[0];
	assign MAP_B_DATA = ch_out[1];
	assign MAP_VALID  = valid_ff;

endmodule

/* design/acfg_pkg.sv */
// Constants for the converter configuration and test-pattern register bank.
// Assumes one sampling-rate clock and register writes on that same clock.
// =====================================================================
package acfg_pkg;

	// =================================================================
	// Register offsets
	localparam logic [7:0] OFS_INPUT_SAMPLING_CONTROL = 8'h11;
	localparam logic [7:0] OFS_MAPPING_LOAD_STROBE    = 8'h13;
	localparam logic [7:0] OFS_PATTERN_VALUE_LOW      = 8'h14;
	localparam logic [7:0] OFS_PATTERN_VALUE_MID      = 8'h15;
	localparam logic [7:0] OFS_PATTERN_SELECT_HIGH    = 8'h16;

	// =================================================================
	// Reset values
	localparam logic [7:0] RST_INPUT_SAMPLING_CONTROL = 8'h00;
	localparam logic [7:0] RST_MAPPING_LOAD_STROBE    = 8'h00;
	localparam logic [7:0] RST_PATTERN_VALUE_LOW      = 8'h00;
	localparam logic [7:0] RST_PATTERN_VALUE_MID      = 8'h00;
	localparam logic [7:0] RST_PATTERN_SELECT_HIGH    = 8'h00;

	// =================================================================
	// Field positions
	localparam int POS_CHAN_A_SINGLE_ENDED  = 5;
	localparam int POS_CHAN_B_SINGLE_ENDED  = 4;
	localparam int POS_DELAY_LOOP_POWERDOWN = 2;
	localparam int POS_AUTOZERO_ENABLE      = 0;
	localparam int POS_MAPPING_LOAD_BIT     = 0;
	localparam int POS_CHAN_B_SEL_LSB       = 5;
	localparam int POS_CHAN_A_SEL_LSB       = 2;
	localparam int POS_PATTERN_HIGH_LSB     = 0;

	// Writable bits of the input control register; the rest read zero.
	localparam logic [7:0] MASK_INPUT_SAMPLING_CONTROL = 8'h35;
	localparam logic [7:0] MASK_MAPPING_LOAD_STROBE    = 8'h01;

	// =================================================================
	// Widths and pattern codes
	localparam int NATIVE_BITS  = 16;
	localparam int PATTERN_BITS = 18;
	localparam int SEL_BITS     = 3;
	localparam int IF_SEL_BITS  = 8;
	localparam int CHANNELS     = 2;

	localparam logic [2:0] SEL_NORMAL   = 3'h0;
	localparam logic [2:0] SEL_RAMP     = 3'h2;
	localparam logic [2:0] SEL_CONSTANT = 3'h3;

endpackage

/* design/acfg_pgen.sv */
// One channel of the test-pattern generator.
// Assumes sample data and its valid strobe arrive on the module clock.
module acfg_pgen (
	input  wire logic                                CLK,
	input  wire logic                                RSTN,
	input  wire logic [acfg_pkg::SEL_BITS-1:0]       SEL,
	input  wire logic [acfg_pkg::PATTERN_BITS-1:0]   VALUE,
	input  wire logic [acfg_pkg::NATIVE_BITS-1:0]    DATA_IN,
	input  wire logic                                VALID_IN,
	output logic      [acfg_pkg::NATIVE_BITS-1:0]    DATA_OUT
);

	// =================================================================
	// Ramp accumulator and output word
	logic [acfg_pkg::PATTERN_BITS-1:0] ramp_ff;
	logic [acfg_pkg::PATTERN_BITS-1:0] nxt_ramp;
	logic [acfg_pkg::NATIVE_BITS-1:0]  data_ff;
	logic [acfg_pkg::NATIVE_BITS-1:0]  nxt_data;
	logic [acfg_pkg::PATTERN_BITS:0]   ramp_sum;

	// One spare bit keeps the carry visible; dropping it is the wrap.
	assign ramp_sum = {1'b0, ramp_ff} + {1'b0, VALUE};

	always_comb begin
		nxt_ramp = ramp_ff;
		nxt_data = data_ff;
		if (VALID_IN) begin
			case (SEL)
				acfg_pkg::SEL_RAMP: begin
					// Accumulator is as wide as the pattern value, so its top bits
					// wrap exactly at the native resolution.
					nxt_ramp = ramp_sum[acfg_pkg::PATTERN_BITS-1:0];
					nxt_data = ramp_ff[acfg_pkg::PATTERN_BITS-1 -: acfg_pkg::NATIVE_BITS];
				end
				acfg_pkg::SEL_CONSTANT: begin
					nxt_ramp = '0;
					nxt_data = VALUE[acfg_pkg::PATTERN_BITS-1 -: acfg_pkg::NATIVE_BITS];
				end
				default: begin
					nxt_ramp = '0;
					nxt_data = DATA_IN;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ramp_ff <= '0;
			data_ff <= '0;
		end else begin
			ramp_ff <= nxt_ramp;
			data_ff <= nxt_data;
		end
	end

	assign DATA_OUT = data_ff;

endmodule

/* bench/acfg_assertions.sv */
// Concurrent checks on the ports of the configuration bank.
// Assumes a bind to acfg_top: one clock, reset asynchronous and active low.
module acfg_assertions (
	input wire logic        CLK,
	input wire logic        RSTN,
	input wire logic        REG_WE,
	input wire logic [7:0]  REG_ADDR,
	input wire logic [7:0]  REG_WDATA,
	input wire logic [7:0]  IF_SEL,
	input wire logic        ADC_VALID,
	input wire logic [15:0] MAP_A_DATA,
	input wire logic        MAP_VALID,
	input wire logic        CHAN_A_SINGLE_ENDED,
	input wire logic        CHAN_B_SINGLE_ENDED,
	input wire logic        DELAY_LOOP_POWERDOWN,
	input wire logic        SAMPLE_TIME_QUARTER,
	input wire logic        AUTOZERO_ENABLE,
	input wire logic        MAPPING_LOAD,
	input wire logic [7:0]  MAPPING_SEL
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// =================================================================
	// Helper logic
	// A load needs a zero written while the stored load bit is one.
	logic armed_ff;
	logic nxt_armed;
	logic wr11;
	logic load_req;
	assign wr11 = REG_WE && REG_ADDR == 8'h11;
	assign load_req = REG_WE && REG_ADDR == 8'h13 && !REG_WDATA[0] && armed_ff;
	assign nxt_armed = (REG_WE && REG_ADDR == 8'h13) ? REG_WDATA[0] : armed_ff;
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			armed_ff <= 1'b0;
		else
			armed_ff <= nxt_armed;
	end
	// =================================================================
	// Assertions
	chk_chan_a_style: assert property (
		wr11 |-> ##2 CHAN_A_SINGLE_ENDED == $past(REG_WDATA[5], 2))
		else $error("channel A input style wrong");
	chk_chan_b_style: assert property (
		wr11 |-> ##2 CHAN_B_SINGLE_ENDED == $past(REG_WDATA[4], 2))
		else $error("channel B input style wrong");
	chk_sample_time: assert property (
		wr11 |-> ##2 DELAY_LOOP_POWERDOWN == $past(REG_WDATA[2], 2)
			&& SAMPLE_TIME_QUARTER != $past(REG_WDATA[2], 2))
		else $error("sampling time control wrong");
	chk_autozero_bit: assert property (
		wr11 |-> ##2 AUTOZERO_ENABLE == $past(REG_WDATA[0], 2))
		else $error("auto-zero enable wrong");
	chk_load_pulse: assert property (
		load_req |=> MAPPING_LOAD && MAPPING_SEL == $past(IF_SEL))
		else $error("mapping load missing");
	chk_load_clears: assert property (
		MAPPING_LOAD |=> !CHAN_A_SINGLE_ENDED && !CHAN_B_SINGLE_ENDED
			&& !DELAY_LOOP_POWERDOWN && SAMPLE_TIME_QUARTER && !AUTOZERO_ENABLE)
		else $error("load did not clear controls");
	chk_sample_hold: assert property (
		!MAP_VALID |-> $stable(MAP_A_DATA))
		else $error("output word moved without a sample");
	chk_valid_follow: assert property (
		ADC_VALID |=> MAP_VALID)
		else $error("sample strobe not passed on");
	cov_load: cover property (load_req ##1 MAPPING_LOAD);
	cov_powerdown: cover property (wr11 ##2 DELAY_LOOP_POWERDOWN);
	cov_wrap: cover property (MAP_VALID && MAP_A_DATA == 16'hffff);
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the configuration and test-pattern bank.
// Assumes acfg_pkg, the design and the checker are compiled before it.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        CLK, RSTN, REG_WE, ADC_VALID, MAP_VALID, MAPPING_LOAD;
	logic        CHAN_A_SINGLE_ENDED, CHAN_B_SINGLE_ENDED, AUTOZERO_ENABLE;
	logic        DELAY_LOOP_POWERDOWN, SAMPLE_TIME_QUARTER;
	logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, IF_SEL, MAPPING_SEL, d;
	logic [15:0] ADC_A_DATA, ADC_B_DATA, MAP_A_DATA, MAP_B_DATA, ea;
	int          n_mismatch = 0;
	int          n_checks = 0;
	acfg_top DUT (
		.CLK                  (CLK),
		.RSTN                 (RSTN),
		.REG_WE               (REG_WE),
		.REG_ADDR             (REG_ADDR),
		.REG_WDATA            (REG_WDATA),
		.REG_RDATA            (REG_RDATA),
		.IF_SEL               (IF_SEL),
		.ADC_A_DATA           (ADC_A_DATA),
		.ADC_B_DATA           (ADC_B_DATA),
		.ADC_VALID            (ADC_VALID),
		.MAP_A_DATA           (MAP_A_DATA),
		.MAP_B_DATA           (MAP_B_DATA),
		.MAP_VALID            (MAP_VALID),
		.CHAN_A_SINGLE_ENDED  (CHAN_A_SINGLE_ENDED),
		.CHAN_B_SINGLE_ENDED  (CHAN_B_SINGLE_ENDED),
		.DELAY_LOOP_POWERDOWN (DELAY_LOOP_POWERDOWN),
		.SAMPLE_TIME_QUARTER  (SAMPLE_TIME_QUARTER),
		.AUTOZERO_ENABLE      (AUTOZERO_ENABLE),
		.MAPPING_LOAD         (MAPPING_LOAD),
		.MAPPING_SEL          (MAPPING_SEL)
	);
	always #20 CLK = ~CLK;
	// =================================================================
	// Access and compare tasks
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge CLK);
		REG_WE <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= v;
		@(posedge CLK);
		REG_WE <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge CLK);
		REG_ADDR <= a;
		@(posedge CLK);
		@(negedge CLK);
		cmp({8'h00, REG_RDATA}, {8'h00, exp});
	endtask
	task automatic samp(input logic [15:0] xa, input logic [15:0] xb);
		@(posedge CLK);
		ADC_VALID <= 1'b1;
		@(posedge CLK);
		ADC_VALID <= 1'b0;
		@(negedge CLK);
		cmp({15'h0, MAP_VALID}, 16'h0001);
		cmp(MAP_A_DATA, xa);
		cmp(MAP_B_DATA, xb);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// =================================================================
	// Main sequence
	initial begin
		CLK = 1'b0;
		RSTN = 1'b0;
		REG_WE = 1'b0;
		REG_ADDR = 8'h00;
		REG_WDATA = 8'h00;
		IF_SEL = 8'h00;
		ADC_VALID = 1'b0;
		ADC_A_DATA = 16'h1234;
		ADC_B_DATA = 16'hfedc;
		repeat (2) @(posedge CLK);
		RSTN <= 1'b1;
		IF_SEL <= 8'h3c;
		wr(8'h13, 8'h01);
		wr(8'h13, 8'h00);
		@(negedge CLK);
		cmp({7'h0, MAPPING_LOAD, MAPPING_SEL}, 16'h013c);
		for (int a = 8'h11; a <= 8'h16; a++)
			rd(a[7:0], 8'h00);
		wr(8'h12, 8'hff);
		rd(8'h12, 8'h00);
		wr(8'h11, 8'hff);
		rd(8'h11, 8'h35);
		for (int i = 0; i < 7; i++) begin
			d = 8'h01 << i;
			wr(8'h11, d);
			repeat (2) @(negedge CLK);
			cmp({11'h0, CHAN_A_SINGLE_ENDED,
				CHAN_B_SINGLE_ENDED, DELAY_LOOP_POWERDOWN, SAMPLE_TIME_QUARTER,
				AUTOZERO_ENABLE}, {11'h0, d[5], d[4], d[2], ~d[2], d[0]});
		end
		wr(8'h14, 8'he5);
		wr(8'h15, 8'hb6);
		for (int c = 0; c < 8; c++) begin
			wr(8'h16, {c[2:0], c[2:0], 2'b10});
			ea = (c == 2) ? 16'h0000 : 16'hadb9;
			if (c == 2 || c == 3)
				samp(ea, ea);
			else
				samp(16'h1234, 16'hfedc);
		end
		rd(8'h14, 8'he5);
		rd(8'h15, 8'hb6);
		rd(8'h16, 8'hfe);
		wr(8'h16, 8'h62);
		samp(16'h1234, 16'hadb9);
		wr(8'h16, 8'h0e);
		samp(16'hadb9, 16'hfedc);
		wr(8'h14, 8'hfc);
		wr(8'h15, 8'hff);
		wr(8'h16, 8'h4b);
		samp(16'h0000, 16'h0000);
		samp(16'hffff, 16'hffff);
		samp(16'hfffe, 16'hfffe);
		wr(8'h11, 8'h35);
		IF_SEL <= 8'h5a;
		wr(8'h13, 8'h01);
		rd(8'h13, 8'h01);
		wr(8'h13, 8'h00);
		@(negedge CLK);
		cmp({7'h0, MAPPING_LOAD, MAPPING_SEL}, 16'h015a);
		@(negedge CLK);
		cmp({10'h0, MAPPING_LOAD, CHAN_A_SINGLE_ENDED, CHAN_B_SINGLE_ENDED,
			DELAY_LOOP_POWERDOWN, SAMPLE_TIME_QUARTER, AUTOZERO_ENABLE}, 16'h0002);
		rd(8'h16, 8'h00);
		rd(8'h13, 8'h00);
		samp(16'h1234, 16'hfedc);
		wr(8'h14, 8'h24);
		wr(8'h16, 8'h48);
		samp(16'h0000, 16'h0000);
		samp(16'h0009, 16'h0009);
		samp(16'h0012, 16'h0012);
		@(posedge CLK);
		IF_SEL <= 8'ha5;
		wr(8'h13, 8'h00);
		@(negedge CLK);
		cmp({7'h0, MAPPING_LOAD, MAPPING_SEL}, 16'h005a);
		end_sim();
	end
	initial begin
		repeat (5000) @(posedge CLK);
		n_mismatch++;
		end_sim();
	end
endmodule

bind acfg_top acfg_assertions u_chk (
	.CLK                  (CLK),
	.RSTN                 (RSTN),
	.REG_WE               (REG_WE),
	.REG_ADDR             (REG_ADDR),
	.REG_WDATA            (REG_WDATA),
	.IF_SEL               (IF_SEL),
	.ADC_VALID            (ADC_VALID),
	.MAP_A_DATA           (MAP_A_DATA),
	.MAP_VALID            (MAP_VALID),
	.CHAN_A_SINGLE_ENDED  (CHAN_A_SINGLE_ENDED),
	.CHAN_B_SINGLE_ENDED  (CHAN_B_SINGLE_ENDED),
	.DELAY_LOOP_POWERDOWN (DELAY_LOOP_POWERDOWN),
	.SAMPLE_TIME_QUARTER  (SAMPLE_TIME_QUARTER),
	.AUTOZERO_ENABLE      (AUTOZERO_ENABLE),
	.MAPPING_LOAD         (MAPPING_LOAD),
	.MAPPING_SEL          (MAPPING_SEL)
);
